//--- shared/dhr_pkg.sv
// Constants, states and register layout for the debug halt and restart controller.
// Assumes a single 100 MHz clock and word-wide APB access to the controller registers.
package dhr_pkg;
    // ==========================================================
    // Register offsets (byte addresses, one aligned word each).
    localparam logic [11:0] DHR_OFF_HALT_CTRL = 12'h000;
    localparam logic [11:0] DHR_OFF_FAULT_STS = 12'h004;
    localparam logic [11:0] DHR_OFF_EXC_MON = 12'h008;
    localparam logic [11:0] DHR_OFF_AUTH = 12'h00c;
    // ==========================================================
    // Field positions.
    localparam int DHR_HC_DEBUGEN = 0;
    localparam int DHR_HC_HALT = 1;
    localparam int DHR_HC_S_HALT = 17;
    localparam int DHR_FS_HALTED = 0;
    localparam int DHR_FS_VCATCH = 3;
    localparam int DHR_FS_EXTERNAL = 4;
    localparam int DHR_EM_VC_RESET = 0;
    localparam int DHR_AU_INVASIVE = 0;
    localparam int DHR_AU_NONINV = 1;
    localparam int DHR_AU_LOCAL_RST = 8;
    // ==========================================================
    // Reset values.
    localparam logic [31:0] DHR_RST_WORD = 32'h0000_0000;
    localparam logic DHR_RST_ACK = 1'b1;
    // ==========================================================
    // Device run state, one-hot.
    typedef enum logic [3:0] {
        DHR_RUN = 4'b0001,
        DHR_HALTED = 4'b0010,
        DHR_ACKED = 4'b0100,
        DHR_LEAVE = 4'b1000
    } dhr_state_e;
    // Host handshake state, one-hot.
    typedef enum logic [2:0] {
        DHR_H_IDLE = 3'b001,
        DHR_H_WAIT_LOW = 3'b010,
        DHR_H_WAIT_HIGH = 3'b100
    } dhr_host_e;
endpackage

//--- shared/dhr_link_if.sv
// Link between the debug halt controller and its external agent.
// Assumes both ends share one clock; the bench joins them.
`timescale 1ns/100ps
interface dhr_link_if;
    logic ext_halt_request_in;
    logic restart_request_in;
    logic restart_ack_out;
    logic halted_out;
    // ==========================================================
    // Device end.
    modport device (input ext_halt_request_in, input restart_request_in,
        output restart_ack_out, output halted_out);
    // Agent end.
    modport agent (output ext_halt_request_in, output restart_request_in,
        input restart_ack_out, input halted_out);
endinterface

//--- logic/dhr_sync.sv
// Two-flop level synchroniser.
// Assumes a level that may change at any time relative to MCLK.
`timescale 1ns/100ps
module dhr_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic d,
    output logic q
);
    logic meta_r;
    // ==========================================================
    // The first flop feeds only the second.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else if (en) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // dhr_sync

//--- logic/dhr_device.sv
// Debug halt and restart controller, processor end, with APB register access.
// Assumes the agent keeps its side of the restart handshake.
// What this block does
// - Authentication inputs gate invasive and non-invasive debug.
// - Invasive enable may be tied high.
// - Agent raises external request to halt.
// - External halt sets external fault flag.
// - Halted output mirrors halt status bit.
// - Agent may use halted as acknowledge.
// - Both active high; request ignored when halted.
// - Restart accepted only when halted and acknowledged.
// - Agent holds restart until acknowledge falls.
// - Agent raises restart only while acknowledge high.
// - Restart rising drops acknowledge.
// - Restart falling starts leaving debug state.
// - Leave debug, then raise acknowledge again.
// - Halted drops while leaving debug state.
// - Power-on reset always includes local reset.
// - Local reset spares debug components.
// - Separate power-on and local reset domains.
// - Reset vector catch raises event at reset exit.
// - Halt only when halting enable is one.
// - Debug bits cleared by power-on reset only.
// - Fault flags clear on writing one.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
module dhr_device
    import dhr_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic LOCAL_RST_N,
    input wire logic CE,
    input wire logic INVASIVE_AUTH_IN,
    input wire logic NONINVASIVE_AUTH_IN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic INVASIVE_OK,
    output logic NONINVASIVE_OK,
    dhr_link_if.device LINK
);
    import dhr_pkg::*;

    dhr_state_e state_r;
    logic debugen_r, halt_req_r, vc_reset_r;
    logic flag_halted_r, flag_vcatch_r, flag_ext_r;
    logic ext_s, rst_s, rst_d_r;
    logic local_rst_d_r, out_of_reset_r, vc_pending_r;
    logic acc, wr, rd, halt_event, ext_event, vc_event, rst_rise, rst_fall;
    logic in_debug;

    // ==========================================================
    // Input synchronisers.
    dhr_sync u_sync_ext (.clk(MCLK), .arst_n(ARST_N), .en(CE),
        .d(LINK.ext_halt_request_in), .q(ext_s));
    dhr_sync u_sync_rst (.clk(MCLK), .arst_n(ARST_N), .en(CE),
        .d(LINK.restart_request_in), .q(rst_s));

    // Bus decode; every access completes in its access phase.
    assign acc = PSEL && PENABLE && CE;
    assign wr = acc && PWRITE;
    assign rd = acc && !PWRITE;
    assign in_debug = (state_r != DHR_RUN);

    // Restart edges and debug events.
    assign rst_rise = rst_s && !rst_d_r;
    assign rst_fall = !rst_s && rst_d_r;
    assign ext_event = ext_s && !in_debug;
    assign vc_event = vc_pending_r && out_of_reset_r;
    assign halt_event = INVASIVE_OK && debugen_r && !in_debug &&
        (ext_event || vc_event || halt_req_r);

    // ==========================================================
    // Authentication flops; invasive implies non-invasive.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            INVASIVE_OK <= 1'b0;
            NONINVASIVE_OK <= 1'b0;
        end else if (CE) begin
            INVASIVE_OK <= INVASIVE_AUTH_IN;
            NONINVASIVE_OK <= INVASIVE_AUTH_IN || NONINVASIVE_AUTH_IN;
        end
    end

    // Local reset tracking: release of the local reset raises the vector catch.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            local_rst_d_r <= 1'b0;
            out_of_reset_r <= 1'b0;
            rst_d_r <= 1'b0;
        end else if (CE) begin
            local_rst_d_r <= LOCAL_RST_N;
            out_of_reset_r <= LOCAL_RST_N && !local_rst_d_r;
            rst_d_r <= rst_s;
        end
    end

    // Vector catch pending: armed at reset exit, consumed next cycle.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            vc_pending_r <= 1'b0;
        end else if (CE) begin
            vc_pending_r <= vc_reset_r && LOCAL_RST_N && !local_rst_d_r;
        end
    end

    // Debug control bits live in the power-on domain only.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            debugen_r <= 1'b0;
            halt_req_r <= 1'b0;
            vc_reset_r <= 1'b0;
        end else if (CE) begin
            if (wr && PADDR == DHR_OFF_HALT_CTRL) begin
                debugen_r <= PWDATA[DHR_HC_DEBUGEN];
                halt_req_r <= PWDATA[DHR_HC_HALT];
            end
            if (wr && PADDR == DHR_OFF_EXC_MON) begin
                vc_reset_r <= PWDATA[DHR_EM_VC_RESET];
            end
        end
    end

    // Sticky fault flags; a new event wins over a clear in the same cycle.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flag_halted_r <= 1'b0;
            flag_vcatch_r <= 1'b0;
            flag_ext_r <= 1'b0;
        end else if (CE) begin
            if (wr && PADDR == DHR_OFF_FAULT_STS) begin
                if (PWDATA[DHR_FS_HALTED]) flag_halted_r <= 1'b0;
                if (PWDATA[DHR_FS_VCATCH]) flag_vcatch_r <= 1'b0;
                if (PWDATA[DHR_FS_EXTERNAL]) flag_ext_r <= 1'b0;
            end
            if (halt_event && halt_req_r) flag_halted_r <= 1'b1;
            if (halt_event && vc_event) flag_vcatch_r <= 1'b1;
            if (halt_event && ext_event) flag_ext_r <= 1'b1;
        end
    end

    // Run state; local reset returns the core to running but spares debug bits.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= DHR_RUN;
        end else if (CE) begin
            if (!LOCAL_RST_N) begin
                state_r <= DHR_RUN;
            end else begin
                unique case (state_r)
                    DHR_RUN: if (halt_event) state_r <= DHR_HALTED;
                    DHR_HALTED: begin
                        if (rst_rise && LINK.restart_ack_out) state_r <= DHR_ACKED;
                        else if (wr && PADDR == DHR_OFF_HALT_CTRL && !PWDATA[DHR_HC_HALT]) state_r <= DHR_RUN;
                    end
                    DHR_ACKED: if (rst_fall) state_r <= DHR_LEAVE;
                    DHR_LEAVE: state_r <= DHR_RUN;
                    default: state_r <= DHR_RUN;
                endcase
            end
        end
    end

    // Link outputs: halted follows the status bit, acknowledge falls and rises.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LINK.halted_out <= 1'b0;
            LINK.restart_ack_out <= DHR_RST_ACK;
        end else if (CE) begin
            LINK.halted_out <= LOCAL_RST_N && (state_r == DHR_HALTED || state_r == DHR_ACKED);
            if (!LOCAL_RST_N) LINK.restart_ack_out <= DHR_RST_ACK;
            else if (state_r == DHR_HALTED && rst_rise && LINK.restart_ack_out) LINK.restart_ack_out <= 1'b0;
            else if (state_r == DHR_LEAVE) LINK.restart_ack_out <= 1'b1;
        end
    end

    // APB read data and response, one access phase per transfer.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= DHR_RST_WORD;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && PADDR > DHR_OFF_AUTH;
            PRDATA <= DHR_RST_WORD;
            if (PSEL && !PENABLE && !PWRITE) begin
                unique case (PADDR)
                    DHR_OFF_HALT_CTRL: begin
                        PRDATA[DHR_HC_DEBUGEN] <= debugen_r;
                        PRDATA[DHR_HC_HALT] <= halt_req_r;
                        PRDATA[DHR_HC_S_HALT] <= LINK.halted_out;
                    end
                    DHR_OFF_FAULT_STS: begin
                        PRDATA[DHR_FS_HALTED] <= flag_halted_r;
                        PRDATA[DHR_FS_VCATCH] <= flag_vcatch_r;
                        PRDATA[DHR_FS_EXTERNAL] <= flag_ext_r;
                    end
                    DHR_OFF_EXC_MON: PRDATA[DHR_EM_VC_RESET] <= vc_reset_r;
                    DHR_OFF_AUTH: begin
                        PRDATA[DHR_AU_INVASIVE] <= INVASIVE_OK;
                        PRDATA[DHR_AU_NONINV] <= NONINVASIVE_OK;
                        PRDATA[DHR_AU_LOCAL_RST] <= LOCAL_RST_N;
                    end
                    default: PRDATA <= DHR_RST_WORD;
                endcase
            end
        end
    end
endmodule // dhr_device

//--- logic/dhr_agent.sv
// External debug agent: raises halt requests and runs the restart handshake.
// Assumes the processor end answers the handshake on the shared clock.
`timescale 1ns/100ps
module dhr_agent
    import dhr_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic HALT_CMD,
    input wire logic RESTART_CMD,
    output logic BUSY,
    output logic HALT_SEEN,
    dhr_link_if.agent LINK
);
    import dhr_pkg::*;

    dhr_host_e hs_r;

    // ==========================================================
    // Halt request held until the halted acknowledge returns.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LINK.ext_halt_request_in <= 1'b0;
            HALT_SEEN <= 1'b0;
        end else if (CE) begin
            HALT_SEEN <= LINK.halted_out;
            if (LINK.halted_out) LINK.ext_halt_request_in <= 1'b0;
            else if (HALT_CMD) LINK.ext_halt_request_in <= 1'b1;
        end
    end

    // Restart handshake.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hs_r <= DHR_H_IDLE;
            LINK.restart_request_in <= 1'b0;
            BUSY <= 1'b0;
        end else if (CE) begin
            unique case (hs_r)
                DHR_H_IDLE: if (RESTART_CMD && LINK.restart_ack_out && LINK.halted_out) begin
                    LINK.restart_request_in <= 1'b1;
                    BUSY <= 1'b1;
                    hs_r <= DHR_H_WAIT_LOW;
                end
                DHR_H_WAIT_LOW: if (!LINK.restart_ack_out) begin
                    LINK.restart_request_in <= 1'b0;
                    hs_r <= DHR_H_WAIT_HIGH;
                end
                DHR_H_WAIT_HIGH: if (LINK.restart_ack_out) begin
                    BUSY <= 1'b0;
                    hs_r <= DHR_H_IDLE;
                end
                default: hs_r <= DHR_H_IDLE;
            endcase
        end
    end
endmodule // dhr_agent

//--- testbench/dhr_link_monitor.sv
// Checker for the halt and restart link between the controller and its agent.
// Assumes one clock; the bench instantiates it beside the link interface.
`timescale 1ns/100ps
module dhr_link_monitor (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic LOCAL_RST_N,
    input wire logic ext_halt_request_in,
    input wire logic restart_request_in,
    input wire logic restart_ack_out,
    input wire logic halted_out
);
    // ==========================================================
    // Handshake checks, quiet while either reset is active.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N || !LOCAL_RST_N);
    ack_fall_cause_a: assert property ($fell(restart_ack_out) |-> halted_out && restart_request_in)
        else $error("acknowledge fell without a held restart while halted");
    restart_ignored_a: assert property (restart_request_in && !halted_out |-> restart_ack_out)
        else $error("restart acted on while not halted");
    ack_drop_bound_a: assert property ($rose(restart_request_in) && halted_out && restart_ack_out
        |-> ##[1:8] !restart_ack_out)
        else $error("acknowledge did not fall after restart");
    ack_low_hold_a: assert property (!restart_ack_out && restart_request_in |=> !restart_ack_out)
        else $error("acknowledge rose while restart still high");
    ack_rise_cause_a: assert property ($rose(restart_ack_out) |-> !restart_request_in
        && !$past(restart_request_in, 2))
        else $error("acknowledge rose without restart falling first");
    leave_bound_a: assert property ($fell(restart_request_in) && !restart_ack_out
        |-> ##[1:10] !halted_out)
        else $error("halted did not fall after restart fell");
    ack_restore_a: assert property ($fell(restart_request_in) && !restart_ack_out
        |-> ##[1:12] restart_ack_out)
        else $error("acknowledge not restored after restart fell");
    leave_order_a: assert property ($rose(restart_ack_out) |-> !halted_out)
        else $error("acknowledge rose while still halted");
    restart_hold_a: assert property ($fell(restart_request_in) |-> !restart_ack_out)
        else $error("restart dropped before acknowledge fell");
    req_release_a: assert property (ext_halt_request_in && halted_out |=> !ext_halt_request_in)
        else $error("halt request still held after halted acknowledge");
endmodule // dhr_link_monitor

//--- testbench/debug_halt_restart_control_tb.sv
// Self-checking bench: controller and agent joined by the link interface.
// Assumes a 100 MHz clock and the APB timing of the controller.
`timescale 1ns/100ps
module debug_halt_restart_control_tb;
    import dhr_pkg::*;
    // ==========================================================
    // Stimulus, outputs and counters.
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [31:0] S_HALT = 32'h0002_0000;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic local_rst_n = 1'b1;
    logic ce = 1'b1;
    logic invasive_auth_in = 1'b1;
    logic noninvasive_auth_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic halt_cmd = 1'b0;
    logic restart_cmd = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, invasive_ok, noninvasive_ok, busy, halt_seen;
    logic [31:0] rdat;
    logic err;
    int n_mismatch = 0;
    int num_checks = 0;
    dhr_link_if link ();
    dhr_device i_dhr_device (.MCLK(mclk), .ARST_N(arst_n), .LOCAL_RST_N(local_rst_n), .CE(ce),
        .INVASIVE_AUTH_IN(invasive_auth_in), .NONINVASIVE_AUTH_IN(noninvasive_auth_in), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .INVASIVE_OK(invasive_ok), .NONINVASIVE_OK(noninvasive_ok),
        .LINK(link));
    dhr_agent i_dhr_agent (.MCLK(mclk), .ARST_N(arst_n), .CE(ce), .HALT_CMD(halt_cmd),
        .RESTART_CMD(restart_cmd), .BUSY(busy), .HALT_SEEN(halt_seen), .LINK(link));
    dhr_link_monitor i_dhr_link_monitor (.MCLK(mclk), .ARST_N(arst_n), .LOCAL_RST_N(local_rst_n),
        .ext_halt_request_in(link.ext_halt_request_in), .restart_request_in(link.restart_request_in),
        .restart_ack_out(link.restart_ack_out), .halted_out(link.halted_out));
    // Free-running clock, 10 ns period.
    always #5 mclk = ~mclk;
    // ==========================================================
    // Shared tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for the answer, and only the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat & mask, exp);
    endtask
    // Waits up to 40 cycles for halted (sel=1) or acknowledge (sel=0) to reach v.
    task automatic wt(input bit sel, input logic v);
        for (int i = 0; i < 40 && (sel ? link.halted_out : link.restart_ack_out) !== v; i++) @(posedge mclk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_auth();
        for (int k = 0; k < 4; k++) begin
            invasive_auth_in <= k[1];
            noninvasive_auth_in <= k[0];
            repeat (4) @(posedge mclk);
            chk({30'h0, noninvasive_ok, invasive_ok}, {30'h0, k[1] | k[0], k[1]});
            rd(DHR_OFF_AUTH, 32'h3, {30'h0, k[1] | k[0], k[1]});
        end
    endtask
    task automatic t_regs();
        rd(DHR_OFF_HALT_CTRL, ALL, DHR_RST_WORD);
        rd(DHR_OFF_FAULT_STS, ALL, DHR_RST_WORD);
        rd(DHR_OFF_EXC_MON, ALL, DHR_RST_WORD);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rdat[30:0]}, 32'h8000_0000);
        apb(1'b1, DHR_OFF_HALT_CTRL, S_HALT);
        rd(DHR_OFF_HALT_CTRL, ALL, 32'h0);
        chk({30'h0, link.restart_ack_out, link.halted_out}, 32'h2);
    endtask
    task automatic t_halt();
        halt_cmd <= 1'b1;
        repeat (12) @(posedge mclk);
        chk({31'h0, link.halted_out}, 32'h0);
        halt_cmd <= 1'b0;
        apb(1'b1, DHR_OFF_HALT_CTRL, 32'h1);
        halt_cmd <= 1'b1;
        wt(1'b1, 1'b1);
        chk({31'h0, link.halted_out}, 32'h1);
        rd(DHR_OFF_HALT_CTRL, S_HALT, S_HALT);
        rd(DHR_OFF_FAULT_STS, 32'h10, 32'h10);
        chk({31'h0, halt_seen}, 32'h1);
        halt_cmd <= 1'b0;
        apb(1'b1, DHR_OFF_FAULT_STS, 32'h0);
        rd(DHR_OFF_FAULT_STS, 32'h10, 32'h10);
        apb(1'b1, DHR_OFF_FAULT_STS, 32'h19);
        rd(DHR_OFF_FAULT_STS, ALL, 32'h0);
        halt_cmd <= 1'b1;
        repeat (10) @(posedge mclk);
        rd(DHR_OFF_FAULT_STS, 32'h10, 32'h0);
        halt_cmd <= 1'b0;
    endtask
    task automatic t_restart();
        restart_cmd <= 1'b1;
        wt(1'b0, 1'b0);
        chk({30'h0, busy, link.restart_ack_out}, 32'h2);
        restart_cmd <= 1'b0;
        wt(1'b0, 1'b1);
        chk({30'h0, link.restart_ack_out, link.halted_out}, 32'h2);
        rd(DHR_OFF_HALT_CTRL, S_HALT, 32'h0);
        chk({31'h0, busy}, 32'h0);
    endtask
    // Halt through the control bit while the agent raises its request, then resume by write.
    task automatic t_hreq();
        apb(1'b1, DHR_OFF_HALT_CTRL, 32'h3);
        halt_cmd <= 1'b1;
        wt(1'b1, 1'b1);
        chk({31'h0, link.halted_out}, 32'h1);
        halt_cmd <= 1'b0;
        rd(DHR_OFF_FAULT_STS, 32'h11, 32'h1);
        apb(1'b1, DHR_OFF_HALT_CTRL, 32'h1);
        wt(1'b1, 1'b0);
        chk({30'h0, link.restart_ack_out, link.halted_out}, 32'h2);
        rd(DHR_OFF_HALT_CTRL, S_HALT | 32'h2, 32'h0);
    endtask
    task automatic t_local();
        apb(1'b1, DHR_OFF_EXC_MON, 32'h1);
        local_rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        local_rst_n <= 1'b1;
        wt(1'b1, 1'b1);
        chk({31'h0, link.halted_out}, 32'h1);
        rd(DHR_OFF_HALT_CTRL, 32'h1, 32'h1);
        rd(DHR_OFF_EXC_MON, 32'h1, 32'h1);
        rd(DHR_OFF_FAULT_STS, 32'h8, 32'h8);
        t_restart();
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        rd(DHR_OFF_HALT_CTRL, ALL, 32'h0);
        rd(DHR_OFF_EXC_MON, ALL, 32'h0);
        rd(DHR_OFF_FAULT_STS, ALL, 32'h0);
    endtask
    task automatic t_ignored();
        restart_cmd <= 1'b1;
        repeat (12) @(posedge mclk);
        chk({30'h0, link.restart_ack_out, link.halted_out}, 32'h2);
    endtask
    // ==========================================================
    // Main sequence and watchdog.
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_auth();
        t_halt();
        t_restart();
        t_hreq();
        t_local();
        t_ignored();
        tally_and_finish();
    end
    // Cuts a hang short well beyond the expected run.
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // debug_halt_restart_control_tb
